// ---- core/osp_serial_port.sv ----
// two-wire slave port into the preamp memory map plus page code decoder
// assumes serial lines come from pins and are resynchronised here
`timescale 1ns/1ps
// Notes on behaviour
// - answer bus address byte 0xBA for writes, 0xBB for reads.
// - pull SDA low during the acknowledge clock after each received byte.
// - write data bytes are acked, stored, then address advances by one.
// - read returns byte at loaded address, address advances per byte.
// - font byte address is bank*0x1000 + glyph*0x40 + row*2 + half.
// - glyphs are 12 by 18, two bytes per row, rows 0 to 0x11.
// - banks 3 and 7 are four-color, all others two-color.
// - bit 0 of 0x8402 selects font plane for four-color reads.
// - low byte has leftmost eight pixels, high nibble-low has last four.
// - page memory holds 512 entries of 9-bit code and 4-bit palette.
// - bit 1 of 0x8402 picks low code byte or code8 plus palette.
// - writing zero to bit 3 of 0x8400 clears the page memory.
// - code 0x001 ends the character line; its palette is ignored.
// - code selects one of 512 glyphs, pointer one of 16 palettes.
// - first entry after each line terminator is a blank-row spacer code.
// - each blank row counts as one glyph pixel row in height scaling.
// - spacer bits 3..0 give blank rows, colour is background palette.
// - code 0x000 ends the displayed window; pointer unused.
module osp_serial_port
  import osp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // serial lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // control state
  output logic [7:0]      frame_control_first,
  output logic [7:0]      font_access,
  output logic            clear_busy,
  // display code fetch
  input  wire logic       disp_frame,
  input  wire logic       disp_rd,
  input  wire logic [8:0] disp_idx,
  output logic            disp_valid,
  output logic            disp_glyph,
  output logic            disp_four_color,
  output logic            line_terminator_code,
  output logic            screen_terminator_code,
  output logic            blank_row_spacer_code,
  output logic [8:0]      glyph_code_field,
  output logic [3:0]      palette_pointer_field,
  output logic [3:0]      disp_blank_rows
);

  logic        scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic        sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic        scl_rise, scl_fall, start_det, stop_det;
  osp_state_t  state_ff, nxt_state;
  logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [1:0]  phase_ff, nxt_phase;
  logic [7:0]  shift_ff, nxt_shift;
  logic [15:0] addr_ff, nxt_addr;
  logic        rd_mode_ff, nxt_rd_mode;
  logic        oe_ff, nxt_oe;
  logic [7:0]  frame_ff, nxt_frame;
  logic [7:0]  facc_ff, nxt_facc;
  logic        clr_ff, nxt_clr;
  logic [8:0]  clr_idx_ff, nxt_clr_idx;
  logic        mem_we;
  logic [8:0]  mem_wa;
  logic [12:0] mem_wd;
  logic [12:0] page_mem [0:OSP_PAGE_DEPTH-1];
  logic [12:0] bus_entry;
  logic        in_page;
  logic [11:0] font_pix;
  logic [7:0]  rd_byte;
  logic        wr_strobe;
  logic        ld_strobe;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  assign scl_rise  = scl_s2_ff && !scl_s3_ff;
  assign scl_fall  = !scl_s2_ff && scl_s3_ff;
  assign start_det = scl_s2_ff && scl_s3_ff && !sda_s2_ff && sda_s3_ff;
  assign stop_det  = scl_s2_ff && scl_s3_ff && sda_s2_ff && !sda_s3_ff;

  // font address: bank in 14:12, glyph 11:6, row 5:1, half in bit 0
  osp_font_rom u_font (
    .bank   (addr_ff[14:12]),
    .glyph  (addr_ff[11:6]),
    .row    (addr_ff[5:1]),
    .plane  (facc_ff[OSP_PLANE_BIT]),
    .pixels (font_pix)
  );

  assign in_page   = (addr_ff >= OSP_PAGE_BASE) && (addr_ff <= OSP_PAGE_LAST);
  assign bus_entry = page_mem[addr_ff[8:0]];

  // read data; reads are legal any time, the master keeps them safe
  always_comb begin
    if (!addr_ff[15]) begin
      if (addr_ff[0]) begin
        rd_byte = {4'h0, font_pix[11:8]};
      end else begin
        rd_byte = font_pix[7:0];
      end
    end else if (in_page) begin
      if (facc_ff[OSP_HALF_BIT]) begin
        rd_byte = {3'h0, bus_entry[12:9], bus_entry[8]};
      end else begin
        rd_byte = bus_entry[7:0];
      end
    end else if (addr_ff == OSP_FRAME_CTRL) begin
      rd_byte = frame_ff;
    end else if (addr_ff == OSP_FONT_ACC) begin
      rd_byte = facc_ff;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // serial state machine and control registers
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_phase   = phase_ff;
    nxt_shift   = shift_ff;
    nxt_addr    = addr_ff;
    nxt_rd_mode = rd_mode_ff;
    nxt_oe      = oe_ff;
    nxt_frame   = frame_ff;
    nxt_facc    = facc_ff;
    nxt_clr     = clr_ff;
    nxt_clr_idx = clr_idx_ff;
    wr_strobe   = 1'b0;
    ld_strobe   = 1'b0;
    if (clr_ff) begin
      nxt_clr_idx = clr_idx_ff + 9'h001;
      nxt_clr     = (clr_idx_ff != OSP_PAGE_TOP);
    end
    if (stop_det) begin
      // address stays for the read that follows
      nxt_state = ST_IDLE;
      nxt_oe    = 1'b0;
    end else if (start_det) begin
      nxt_state   = ST_RX;
      nxt_bit_cnt = 4'h0;
      nxt_phase   = 2'h0;
      nxt_rd_mode = 1'b0;
      nxt_oe      = 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise && bit_cnt_ff != 4'h8) begin
            nxt_shift   = {shift_ff[6:0], sda_s2_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            nxt_state = ST_ACK;
            nxt_oe    = 1'b1;
            case (phase_ff)
              2'h0: begin
                if (shift_ff[7:1] == OSP_SLAVE_ADDR) begin
                  nxt_rd_mode = shift_ff[0];
                  nxt_phase   = 2'h1;
                end else begin
                  nxt_state = ST_IDLE;
                  nxt_oe    = 1'b0;
                end
              end
              2'h1: begin
                nxt_addr[7:0] = shift_ff;
                nxt_phase     = 2'h2;
              end
              2'h2: begin
                nxt_addr[15:8] = shift_ff;
                nxt_phase      = 2'h3;
              end
              default: begin
                wr_strobe = 1'b1;
                nxt_addr  = addr_ff + 16'h0001;
                if (addr_ff == OSP_FRAME_CTRL) begin
                  nxt_frame = shift_ff;
                  if (!shift_ff[OSP_CLR_BIT]) begin
                    nxt_clr     = 1'b1;
                    nxt_clr_idx = 9'h000;
                  end
                end else if (addr_ff == OSP_FONT_ACC) begin
                  nxt_facc = shift_ff;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_mode_ff) begin
              ld_strobe   = 1'b1;
              nxt_shift   = rd_byte;
              nxt_addr    = addr_ff + 16'h0001;
              nxt_oe      = !rd_byte[7];
              nxt_bit_cnt = 4'h1;
              nxt_state   = ST_TX;
            end else begin
              nxt_oe      = 1'b0;
              nxt_bit_cnt = 4'h0;
              nxt_state   = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              nxt_oe    = 1'b0;
              nxt_state = ST_TXACK;
            end else begin
              nxt_oe      = !shift_ff[6];
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            nxt_state = sda_s2_ff ? ST_IDLE : ST_ACK;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      phase_ff   <= 2'h0;
      shift_ff   <= 8'h00;
      addr_ff    <= 16'h0000;
      rd_mode_ff <= 1'b0;
      oe_ff      <= 1'b0;
      frame_ff   <= OSP_FRAME_RST;
      facc_ff    <= OSP_FONT_ACC_RST;
      clr_ff     <= 1'b0;
      clr_idx_ff <= 9'h000;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      phase_ff   <= nxt_phase;
      shift_ff   <= nxt_shift;
      addr_ff    <= nxt_addr;
      rd_mode_ff <= nxt_rd_mode;
      oe_ff      <= nxt_oe;
      frame_ff   <= nxt_frame;
      facc_ff    <= nxt_facc;
      clr_ff     <= nxt_clr;
      clr_idx_ff <= nxt_clr_idx;
    end
  end

  // bus writes lose to the clear sweep so the sweep always finishes
  always_comb begin
    mem_we = 1'b0;
    mem_wa = addr_ff[8:0];
    mem_wd = bus_entry;
    if (clr_ff) begin
      mem_we = 1'b1;
      mem_wa = clr_idx_ff;
      mem_wd = 13'h0000;
    end else if (wr_strobe && in_page) begin
      mem_we = 1'b1;
      if (facc_ff[OSP_HALF_BIT]) begin
        mem_wd = {shift_ff[4:1], shift_ff[0], bus_entry[7:0]};
      end else begin
        mem_wd = {bus_entry[12:8], shift_ff};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      page_mem[mem_wa] <= mem_wd;
    end
  end

  // display side: classify fetched page entries
  logic [12:0] d_entry;
  logic        line_start_ff, nxt_line_start;
  logic        dv_ff, dg_ff, d4_ff, deol_ff, deos_ff, dskp_ff;
  logic        nxt_dv, nxt_dg, nxt_d4, nxt_deol, nxt_deos, nxt_dskp;
  logic [8:0]  dcode_ff, nxt_dcode;
  logic [3:0]  dpal_ff, nxt_dpal, drows_ff, nxt_drows;

  assign d_entry = page_mem[disp_idx];

  always_comb begin
    nxt_line_start = line_start_ff;
    nxt_dv    = 1'b0;
    nxt_dg    = 1'b0;
    nxt_d4    = 1'b0;
    nxt_deol  = 1'b0;
    nxt_deos  = 1'b0;
    nxt_dskp  = 1'b0;
    nxt_dcode = dcode_ff;
    nxt_dpal  = dpal_ff;
    nxt_drows = drows_ff;
    if (disp_frame) begin
      nxt_line_start = 1'b0;
    end else if (disp_rd) begin
      nxt_dv    = 1'b1;
      nxt_dcode = d_entry[8:0];
      nxt_dpal  = d_entry[12:9];
      if (line_start_ff) begin
        // rows count in glyph pixel rows downstream
        nxt_dskp       = 1'b1;
        nxt_drows      = d_entry[3:0];
        nxt_line_start = 1'b0;
      end else if (d_entry[8:0] == OSP_CODE_EOS) begin
        nxt_deos = 1'b1;
      end else if (d_entry[8:0] == OSP_CODE_EOL) begin
        nxt_deol       = 1'b1;
        nxt_line_start = 1'b1;
      end else begin
        nxt_dg = 1'b1;
        nxt_d4 = (d_entry[7:6] == 2'h3);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_start_ff <= 1'b0;
      dv_ff    <= 1'b0;
      dg_ff    <= 1'b0;
      d4_ff    <= 1'b0;
      deol_ff  <= 1'b0;
      deos_ff  <= 1'b0;
      dskp_ff  <= 1'b0;
      dcode_ff <= 9'h000;
      dpal_ff  <= 4'h0;
      drows_ff <= 4'h0;
    end else begin
      line_start_ff <= nxt_line_start;
      dv_ff    <= nxt_dv;
      dg_ff    <= nxt_dg;
      d4_ff    <= nxt_d4;
      deol_ff  <= nxt_deol;
      deos_ff  <= nxt_deos;
      dskp_ff  <= nxt_dskp;
      dcode_ff <= nxt_dcode;
      dpal_ff  <= nxt_dpal;
      drows_ff <= nxt_drows;
    end
  end

  assign sda_out                = 1'b0;
  assign sda_oe                 = oe_ff;
  assign frame_control_first    = frame_ff;
  assign font_access            = facc_ff;
  assign clear_busy             = clr_ff;
  assign disp_valid             = dv_ff;
  assign disp_glyph             = dg_ff;
  assign disp_four_color        = d4_ff;
  assign line_terminator_code   = deol_ff;
  assign screen_terminator_code = deos_ff;
  assign blank_row_spacer_code  = dskp_ff;
  assign glyph_code_field       = dcode_ff;
  assign palette_pointer_field  = dpal_ff;
  assign disp_blank_rows        = drows_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  addr_match_a: assert property (
    (state_ff == ST_RX && scl_fall && bit_cnt_ff == 4'h8 && phase_ff == 2'h0
     && !start_det && !stop_det)
    |=> (oe_ff == ($past(shift_ff[7:1]) == OSP_SLAVE_ADDR)))
    else $error("bus address decode wrong");
  rx_ack_hold_a: assert property (
    (state_ff == ST_ACK && !rd_mode_ff) |-> oe_ff)
    else $error("receive ack not driven");
  wr_advance_a: assert property (
    (wr_strobe && !stop_det && !start_det)
    |=> addr_ff == $past(addr_ff) + 16'h0001)
    else $error("write address did not advance");
  rd_advance_a: assert property (
    ld_strobe |=> (addr_ff == $past(addr_ff) + 16'h0001) && state_ff == ST_TX)
    else $error("read address did not advance");
  clear_start_a: assert property (
    (wr_strobe && addr_ff == OSP_FRAME_CTRL && !shift_ff[OSP_CLR_BIT])
    |=> clr_ff && clr_idx_ff == 9'h000)
    else $error("page clear not started");
  stop_release_a: assert property (
    stop_det |=> !oe_ff && state_ff == ST_IDLE && $stable(addr_ff))
    else $error("stop did not release line");
  line_end_a: assert property (
    (disp_rd && !disp_frame && !line_start_ff && d_entry[8:0] == OSP_CODE_EOL)
    |=> deol_ff && line_start_ff && !dg_ff)
    else $error("line terminator missed");
  spacer_rows_a: assert property (
    (disp_rd && !disp_frame && line_start_ff)
    |=> dskp_ff && !dg_ff && drows_ff == $past(d_entry[3:0]))
    else $error("spacer code not decoded");
  screen_end_a: assert property (
    (disp_rd && !disp_frame && !line_start_ff && d_entry[8:0] == 9'h000)
    |=> deos_ff && !dg_ff)
    else $error("screen terminator missed");

endmodule

// ---- core/osp_pkg.sv ----
// package for the serial memory port: bus address, memory map, code values
// assumes one 20 MHz system clock; all serial lines are sampled by it
package osp_pkg;

  // bus address, register map and reset values
  localparam logic [6:0]  OSP_SLAVE_ADDR   = 7'h5D;
  localparam logic [15:0] OSP_FRAME_CTRL   = 16'h8400;
  localparam logic [15:0] OSP_FONT_ACC     = 16'h8402;
  localparam logic [15:0] OSP_PAGE_BASE    = 16'h8000;
  localparam logic [15:0] OSP_PAGE_LAST    = 16'h81FF;
  localparam logic [7:0]  OSP_FRAME_RST    = 8'h98;
  localparam logic [7:0]  OSP_FONT_ACC_RST = 8'h00;

  // field positions
  localparam int OSP_CLR_BIT   = 3;
  localparam int OSP_PLANE_BIT = 0;
  localparam int OSP_HALF_BIT  = 1;

  // font geometry
  localparam int         OSP_GLYPH_COLS = 12;
  localparam logic [4:0] OSP_ROW_LAST   = 5'h11;

  // page memory
  localparam int         OSP_PAGE_DEPTH = 512;
  localparam logic [8:0] OSP_PAGE_TOP   = 9'h1FF;
  localparam logic [8:0] OSP_CODE_EOS   = 9'h000;
  localparam logic [8:0] OSP_CODE_EOL   = 9'h001;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_ACK   = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } osp_state_t;

endpackage

// ---- core/osp_font_rom.sv ----
// glyph pixel store read back over the serial port
// assumes the caller registers the result; content is a stand-in pattern
`timescale 1ns/1ps
module osp_font_rom
  import osp_pkg::*;
(
  // glyph select
  input  wire logic [2:0]  bank,
  input  wire logic [5:0]  glyph,
  input  wire logic [4:0]  row,
  input  wire logic        plane,
  // pixel row, index 0 is leftmost
  output logic [OSP_GLYPH_COLS-1:0] pixels
);

  logic four_color;

  // banks 3 and 7 carry two planes, the rest one
  assign four_color = (bank[1:0] == 2'h3);

  // mask content is not modelled; a deterministic pattern stands in
  always_comb begin
    if (row > OSP_ROW_LAST) begin
      pixels = 12'h000;
    end else if (plane && !four_color) begin
      pixels = 12'h000;
    end else begin
      pixels = {bank, glyph, row[2:0]} ^ {12{plane}};
    end
  end

endmodule

// ---- test/osp_i2c_master.sv ----
// bus master model for the two-wire port, open drain on the data line
// assumes the bench resolves the data wire with a pull-up to high
`timescale 1ns/1ps
module osp_i2c_master (
  // clock and resolved wire level
  input  wire logic ref_clk,
  input  wire logic sda_line,
  // lines driven by the master
  output logic      scl_pin,
  output logic      sda_low
);
  // four system cycles a half period gives the 400 ns link clock
  localparam int HALF = 4;

  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // data moves mid-low only, so it never changes while the clock is high
  task automatic pulse(input logic low, output logic seen);
    tick(2);
    sda_low = low;
    tick(2);
    scl_pin = 1'b1;
    tick(HALF - 1);
    seen = sda_line;
    tick(1);
    scl_pin = 1'b0;
  endtask

  task automatic bus_start();
    tick(2);
    sda_low = 1'b0;
    tick(2);
    scl_pin = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl_pin = 1'b0;
  endtask

  task automatic bus_stop();
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl_pin = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask

  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      pulse(~d[i], seen);
    end
    pulse(1'b0, seen);
    ack = ~seen;
  endtask

  // a broken-off byte: only four bits reach the wire before a stop
  task automatic tx_half(input logic [3:0] d);
    logic seen;
    for (int i = 3; i >= 0; i--) begin
      pulse(~d[i], seen);
    end
  endtask

  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b0, seen);
      d[i] = seen;
    end
    pulse(~last, seen);
  endtask
endmodule

// ---- test/osp_serial_port_tb.sv ----
// self-checking bench for the two-wire memory port and page code decoder
// assumes the master model drives the link; data wire has a pull-up
`timescale 1ns/1ps
module osp_serial_port_tb
  import osp_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       disp_frame = 1'b0;
  logic       disp_rd = 1'b0;
  logic [8:0] disp_idx = 9'h000;
  logic       scl_pin, sda_low, sda_out, sda_oe, clear_busy;
  logic [7:0] frame_control_first, font_access;
  logic       disp_valid, disp_glyph, disp_four_color;
  logic       line_terminator_code, screen_terminator_code;
  logic       blank_row_spacer_code;
  logic [8:0] glyph_code_field;
  logic [3:0] palette_pointer_field, disp_blank_rows;
  wire        sda_line = ~(sda_low | sda_oe);
  int         bad_count = 0;
  int         total_checks = 0;
  // stand-in pixel row of bank 3, glyph 5, row 0x11
  localparam logic [11:0] PIX = {3'h3, 6'h05, 3'h1};
  localparam logic [15:0] FONT_A = (16'h3 * 16'h1000) + (16'h05 * 16'h0040)
                                   + (16'h11 * 16'h0002);

  always #25 ref_clk = ~ref_clk;

  osp_serial_port u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_pin), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .frame_control_first(frame_control_first), .font_access(font_access),
    .clear_busy(clear_busy), .disp_frame(disp_frame), .disp_rd(disp_rd),
    .disp_idx(disp_idx), .disp_valid(disp_valid), .disp_glyph(disp_glyph),
    .disp_four_color(disp_four_color),
    .line_terminator_code(line_terminator_code),
    .screen_terminator_code(screen_terminator_code),
    .blank_row_spacer_code(blank_row_spacer_code),
    .glyph_code_field(glyph_code_field),
    .palette_pointer_field(palette_pointer_field),
    .disp_blank_rows(disp_blank_rows)
  );

  osp_i2c_master u_mst (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl_pin(scl_pin),
    .sda_low(sda_low)
  );

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] d);
    logic ack;
    u_mst.tx_byte(d, ack);
    check("ack", {15'h0000, ack}, 16'h0001);
  endtask

  task automatic bus_addr(input logic [15:0] a);
    u_mst.bus_start();
    put({OSP_SLAVE_ADDR, 1'b0});
    put(a[7:0]);
    put(a[15:8]);
  endtask

  task automatic wr1(input logic [15:0] a, input logic [7:0] d);
    bus_addr(a);
    put(d);
    u_mst.bus_stop();
  endtask

  // reads are legal at any time, so a stop closes the address phase and a fresh start opens the read
  task automatic rd_open(input logic [15:0] a);
    bus_addr(a);
    u_mst.bus_stop();
    u_mst.bus_start();
    put({OSP_SLAVE_ADDR, 1'b1});
  endtask

  task automatic get(input string what, input logic [7:0] exp,
                     input logic [7:0] mask, input logic last);
    logic [7:0] d;
    u_mst.rx_byte(last, d);
    check(what, {8'h00, d & mask}, {8'h00, exp & mask});
  endtask

  task automatic fetch(input logic [8:0] idx, input logic [4:0] kind,
                       input logic [8:0] code, input logic [3:0] pal,
                       input logic [3:0] rows);
    disp_idx = idx;
    disp_rd = 1'b1;
    @(negedge ref_clk);
    disp_rd = 1'b0;
    check("disp_kind", {10'h000, disp_valid, disp_glyph,
          disp_four_color, line_terminator_code, screen_terminator_code,
          blank_row_spacer_code}, {10'h000, 1'b1, kind});
    check("disp_code", {7'h00, glyph_code_field}, {7'h00, code});
    check("disp_pal", {12'h000, palette_pointer_field},
          {12'h000, pal});
    check("disp_rows", {12'h000, disp_blank_rows}, {12'h000, rows});
    // one idle cycle so the next fetch never re-raises the strobe at once
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    check("sda_oe", {15'h0000, sda_oe}, 16'h0000);
    check("sda_out", {15'h0000, sda_out}, 16'h0000);
    check("frame", {8'h00, frame_control_first},
          {8'h00, OSP_FRAME_RST});
    check("font_acc", {8'h00, font_access},
          {8'h00, OSP_FONT_ACC_RST});
    check("clear_busy", {15'h0000, clear_busy}, 16'h0000);
  endtask

  task automatic t_bad_addr();
    logic ack;
    u_mst.bus_start();
    u_mst.tx_byte(8'hBC, ack);
    check("foreign_ack", {15'h0000, ack}, 16'h0000);
    u_mst.bus_stop();
  endtask

  task automatic t_clear();
    int n;
    wr1(OSP_FRAME_CTRL, 8'h90);
    check("clear_run", {15'h0000, clear_busy}, 16'h0001);
    check("frame_wr", {8'h00, frame_control_first}, 16'h0090);
    n = 0;
    while (clear_busy === 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    check("clear_end", {15'h0000, clear_busy}, 16'h0000);
    rd_open(OSP_PAGE_BASE);
    get("cleared", 8'h00, 8'hFF, 1'b1);
    u_mst.bus_stop();
  endtask

  task automatic t_page();
    bus_addr(OSP_PAGE_BASE);
    put(8'h05);
    put(8'h01);
    put(8'h03);
    put(8'hC2);
    put(8'h00);
    u_mst.bus_stop();
    rd_open(OSP_PAGE_BASE);
    get("page0", 8'h05, 8'hFF, 1'b0);
    get("page1", 8'h01, 8'hFF, 1'b1);
    u_mst.bus_stop();
    wr1(OSP_FONT_ACC, 8'h02);
    check("font_acc", {8'h00, font_access}, 16'h0002);
    wr1(OSP_PAGE_BASE, 8'h1B);
    rd_open(OSP_PAGE_BASE);
    get("page0_hi", 8'h1B, 8'h1F, 1'b1);
    u_mst.bus_stop();
  endtask

  task automatic t_fetch();
    disp_frame = 1'b1;
    @(negedge ref_clk);
    disp_frame = 1'b0;
    fetch(9'h000, 5'b10000, 9'h105, 4'hD, 4'h0);
    fetch(9'h001, 5'b00100, 9'h001, 4'h0, 4'h0);
    fetch(9'h002, 5'b00001, 9'h003, 4'h0, 4'h3);
    fetch(9'h003, 5'b11000, 9'h0C2, 4'h0, 4'h3);
    fetch(9'h004, 5'b00010, 9'h000, 4'h0, 4'h3);
  endtask

  task automatic t_font();
    wr1(OSP_FONT_ACC, 8'h00);
    rd_open(FONT_A);
    get("font_lo", PIX[7:0], 8'hFF, 1'b0);
    get("font_hi", {4'h0, PIX[11:8]}, 8'h0F, 1'b1);
    u_mst.bus_stop();
    wr1(OSP_FONT_ACC, 8'h01);
    rd_open(FONT_A);
    get("plane1_lo", ~PIX[7:0], 8'hFF, 1'b0);
    get("plane1_hi", {4'h0, ~PIX[11:8]}, 8'h0F, 1'b1);
    u_mst.bus_stop();
  endtask

  task automatic t_stop_mid();
    wr1(OSP_PAGE_LAST, 8'h5A);
    bus_addr(OSP_PAGE_LAST);
    u_mst.tx_half(4'h3);
    u_mst.bus_stop();
    check("released", {15'h0000, sda_oe}, 16'h0000);
    u_mst.bus_start();
    put({OSP_SLAVE_ADDR, 1'b1});
    get("kept_addr", 8'h5A, 8'hFF, 1'b1);
    u_mst.bus_stop();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    t_reset();
    t_bad_addr();
    t_clear();
    t_page();
    t_fetch();
    t_font();
    t_stop_mid();
    print_verdict();
  end

  // the whole sequence needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule
